// >>> design/mvc_arbiter.sv
/*
  Combinational priority picker over every vector of the controller.
  Assumes pending bits and priorities come from flops on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mvc_arbiter
  import mvc_pkg::*;
(
  input  wire logic [mvc_pkg::NUM_VEC-1:0]       pending,
  input  wire logic [mvc_pkg::NUM_VEC-1:0][2:0]  prio,
  output var  logic                              found,
  output var  mvc_pkg::mvc_vec_t                 win_vec,
  output var  mvc_pkg::mvc_key_t                 win_key
);
  import mvc_pkg::*;

  // Strict less-than keeps the earlier, lower vector on equal keys.
  always_comb begin
    found   = 1'b0;
    win_vec = VEC_NONE;
    win_key = KEY_IDLE;
    for (int v = 1; v < NUM_VEC; v++) begin
      if (pending[v] && mvc_key(7'(v), prio[v]) < win_key) begin // see [R21]
        found   = 1'b1;
        win_vec = 7'(v);
        win_key = mvc_key(7'(v), prio[v]);
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/mvc_controller.sv
/*
  Master vector controller: gathers peripheral, DMA, analog, memory-error
  and core exception requests, ranks them by fixed and programmable levels
  and presents one vector with its table entry address to the core.
  Assumes all requests except the external NMI pin are on core_clk, and
  that the core answers a presented vector with core_ack and signals the
  end of a handler with core_return.
*/
`timescale 1ns/1ps
`default_nettype none
module mvc_controller
  import mvc_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          power_on_reset_request,
  input  wire logic                          system_reset_request,
  input  wire logic                          clock_fail,
  input  wire logic                          ctrl_pie_error,
  input  wire logic                          ctrl_nmi_wd_timeout,
  input  wire logic                          ext_nmi_pin,
  input  wire logic                          nmi_wd_expired,
  input  wire logic                          mem_manage_fault,
  input  wire logic                          usage_fault,
  input  wire logic                          bus_access_error,
  input  wire logic                          bus_access_imprecise,
  input  wire logic                          ram_uncorr_error,
  input  wire logic                          flash_uncorr_error,
  input  wire logic [mvc_pkg::NUM_FAULT-1:0] fault_enable,
  input  wire logic                          svc_request,
  input  wire logic                          debug_mon_request,
  input  wire logic                          pendsv_request,
  input  wire logic                          systick_request,
  input  wire logic [mvc_pkg::NUM_IRQ-1:0]   periph_irq,
  input  wire logic [mvc_pkg::NUM_IRQ-1:0]   irq_enable,
  input  wire logic [mvc_pkg::NUM_DMA_CH-1:0] dma_req,
  input  wire logic [mvc_pkg::NUM_DMA_CH-1:0] dma_chan_enable,
  input  wire logic                          dma_done_irq,
  input  wire logic [1:0]                    wdog_irq,
  input  wire logic [3:0]                    can_irq,
  input  wire logic [1:0]                    i2c_irq,
  input  wire logic [7:0]                    adc1_eoc,
  input  wire logic [7:0]                    adc2_eoc,
  input  wire logic [3:0]                    control_to_master_ipc_irq,
  input  wire logic                          ram_single_error,
  input  wire logic                          pll_unlock,
  input  wire logic                          flash_single_error,
  input  wire mvc_pkg::mvc_prio_wr_t         prio_wr,
  input  wire mvc_pkg::mvc_vtor_wr_t         vtor_wr,
  input  wire logic                          core_ack,
  input  wire logic                          core_return,
  output var  logic                          exc_valid,
  output var  mvc_pkg::mvc_exc_t             exc,
  output var  mvc_pkg::mvc_vec_t             active_vector,
  output var  logic [31:0]                   vector_table_offset,
  output var  logic                          vtor_wr_rejected,
  output var  logic                          nonmaskable_interrupt_line,
  output var  logic                          hard_fault_exception,
  output var  logic [7:0]                    conversion_done_irqs,
  output var  logic [mvc_pkg::NUM_DMA_CH-1:0] dma_engine_req,
  output var  logic                          nmi_wd_reset_request
);
  import mvc_pkg::*;

  logic                         nmi_pin_sync;
  logic                         reset_req_q;
  logic [15:1]                  exc_pend;
  logic [15:1]                  next_exc_pend;
  logic [NUM_VEC-1:0][2:0]      prio_q;
  logic [NUM_VEC-1:0]           pend;
  logic [NUM_IRQ-1:0]           irq_lines;
  mvc_key_t                     act_key;
  logic                         bus_imprecise_q;
  logic                         win_found;
  mvc_vec_t                     win_vec;
  mvc_key_t                     win_key;
  logic                         after_rst;

  mvc_sync #(
    .WIDTH    (1)
  ) u_nmi_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (ext_nmi_pin),
    .sync_out (nmi_pin_sync)
  );

  wire logic reset_req_now  = power_on_reset_request | system_reset_request;
  wire logic reset_req_rise = reset_req_now & ~reset_req_q;
  wire logic nmi_now = clock_fail | ctrl_pie_error | nmi_pin_sync |
                       ctrl_nmi_wd_timeout;                     // see [R9]
  wire logic nmi_rise = nmi_now & ~nonmaskable_interrupt_line;
  wire logic take     = exc_valid & core_ack;
  wire logic [7:0] adc_and = adc1_eoc & adc2_eoc;               // see [R20]

  // Fault sources in vector order: memory management, bus, usage.
  wire logic [NUM_FAULT-1:0] fault_raise = {
    usage_fault,
    bus_access_error | ram_uncorr_error | flash_uncorr_error,   // see [R10]
    mem_manage_fault
  };

  // A fault that is disabled, already active, or cannot preempt the
  // running handler has no way to be serviced and becomes a hard fault.
  logic [NUM_FAULT-1:0] fault_stuck;
  always_comb begin
    for (int i = 0; i < NUM_FAULT; i++) begin
      fault_stuck[i] = ~fault_enable[i] |
                       (active_vector == VEC_MEM + 7'(i)) |
                       (mvc_key(VEC_MEM + 7'(i), prio_q[4 + i]) >= act_key);
    end
  end
  wire logic [NUM_FAULT-1:0] fault_take = fault_raise & ~fault_stuck;
  wire logic escalate = |(fault_raise & fault_stuck);            // see [R3]

  wire logic vtor_ok = vtor_wr.en && vtor_wr.privileged &&
                       vtor_wr.data >= VTOR_MIN &&
                       vtor_wr.data <= VTOR_MAX &&
                       vtor_wr.data[VTOR_ALIGN_BITS-1:0] == '0;  // see [R18]

  wire logic prio_ok = prio_wr.en && mvc_is_prog(prio_wr.vector);

  // Interrupt line assembly. DMA-capable peripherals reach the controller
  // only while their channel is off; otherwise the engine owns the request.
  always_comb begin
    irq_lines = periph_irq;
    for (int c = 0; c < NUM_DMA_CH; c++) begin
      dma_engine_req[c] = dma_req[c] & dma_chan_enable[c];     // see [R13]
      irq_lines[DMA_IRQ_MAP[c]] = periph_irq[DMA_IRQ_MAP[c]] |
        (dma_req[c] & ~dma_chan_enable[c]);                    // see [R14]
    end
    irq_lines[IRQ_DMA_SW]    = periph_irq[IRQ_DMA_SW] | dma_done_irq;
    irq_lines[IRQ_WDOG]      = |wdog_irq;                      // see [R12]
    irq_lines[IRQ_I2C0]      = i2c_irq[0];                     // see [R15]
    irq_lines[IRQ_I2C1]      = i2c_irq[1];
    irq_lines[IRQ_CAN+:4]    = can_irq;
    irq_lines[IRQ_ADC+:8]    = adc_and;
    irq_lines[IRQ_IPC+:4]    = control_to_master_ipc_irq;
    irq_lines[IRQ_RAM_SEC]   = ram_single_error;               // see [R11]
    irq_lines[IRQ_PLL]       = pll_unlock;
    irq_lines[IRQ_FLASH_SEC] = flash_single_error;
  end

  // Reserved vectors 7-10 and 13 never pend; bit n lands on vector n+16.
  always_comb begin
    pend = '0;
    pend[15:1] = exc_pend;                                     // see [R4]
    pend[10:7] = 4'h0;                                         // see [R6]
    pend[13]   = 1'b0;
    pend[NUM_VEC-1:16] = irq_lines & irq_enable;               // see [R5]
  end

  // Set wins over the clear that a core acknowledge applies.
  always_comb begin
    next_exc_pend = exc_pend;
    if (take && exc.vector <= VEC_SYSTICK && exc.vector != VEC_NONE) begin
      next_exc_pend[exc.vector[3:0]] = 1'b0;
    end
    if (reset_req_rise) begin
      next_exc_pend[VEC_RESET] = 1'b1;                         // see [R1]
    end
    if (nmi_rise) begin
      next_exc_pend[VEC_NMI] = 1'b1;                           // see [R2]
    end
    if (escalate) begin
      next_exc_pend[VEC_HARD] = 1'b1;                          // see [R3]
    end
    for (int i = 0; i < NUM_FAULT; i++) begin
      if (fault_take[i]) begin
        next_exc_pend[4 + i] = 1'b1;
      end
    end
    if (svc_request) begin
      next_exc_pend[VEC_SVC] = 1'b1;                           // see [R4]
    end
    if (debug_mon_request) begin
      next_exc_pend[VEC_DEBUG] = 1'b1;
    end
    if (pendsv_request) begin
      next_exc_pend[VEC_PENDSV] = 1'b1;
    end
    if (systick_request) begin
      next_exc_pend[VEC_SYSTICK] = 1'b1;
    end
  end

  mvc_arbiter u_arbiter (
    .pending (pend),
    .prio    (prio_q),
    .found   (win_found),
    .win_vec (win_vec),
    .win_key (win_key)
  );

  wire logic next_valid = win_found && (win_key < act_key) && !take;
  wire logic win_async  = (win_vec == VEC_BUS) ? bus_imprecise_q :
                          !(win_vec inside {VEC_HARD, VEC_MEM, VEC_USAGE,
                                            VEC_SVC, VEC_DEBUG});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      exc_pend        <= '0;
      reset_req_q     <= 1'b0;
      bus_imprecise_q <= 1'b0;
      after_rst       <= 1'b0;
    end else begin
      exc_pend        <= next_exc_pend;
      reset_req_q     <= reset_req_now;
      after_rst       <= 1'b1;
      if (fault_raise[1]) begin
        bus_imprecise_q <= bus_access_imprecise;               // see [R10]
      end
    end
  end

  // A reset request returns the table and all priorities to their
  // reset state before the reset vector is presented.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vector_table_offset <= VTOR_RESET;                      // see [R17]
      vtor_wr_rejected    <= 1'b0;
    end else if (reset_req_rise) begin
      vector_table_offset <= VTOR_RESET;                      // see [R17]
      vtor_wr_rejected    <= 1'b0;
    end else begin
      vtor_wr_rejected <= vtor_wr.en & ~vtor_ok;              // see [R19]
      if (vtor_ok) begin
        vector_table_offset <= vtor_wr.data;                  // see [R18]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prio_q <= '{default: PRIO_RESET};                       // see [R7]
    end else if (reset_req_rise) begin
      prio_q <= '{default: PRIO_RESET};                       // see [R7]
    end else if (prio_ok) begin
      prio_q[prio_wr.vector] <= prio_wr.level;
    end
  end

  // Only one level of activity is tracked; a return drops to thread level.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      exc_valid     <= 1'b0;
      exc           <= '0;
      active_vector <= VEC_NONE;
      act_key       <= KEY_IDLE;
    end else begin
      exc_valid <= next_valid;
      if (next_valid) begin
        exc.vector       <= win_vec;
        exc.handler_addr <= mvc_entry_addr(vector_table_offset, win_vec);
        exc.sp_addr      <= vector_table_offset + SP_ENTRY_OFFSET; // see [R8]
        exc.asynchronous <= win_async;
      end
      if (take) begin
        active_vector <= exc.vector;
        act_key       <= mvc_key(exc.vector, prio_q[exc.vector]);
      end else if (core_return) begin
        active_vector <= VEC_NONE;
        act_key       <= KEY_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nonmaskable_interrupt_line <= 1'b0;
      conversion_done_irqs       <= 8'h00;
      nmi_wd_reset_request       <= 1'b0;
    end else begin
      nonmaskable_interrupt_line <= nmi_now;
      conversion_done_irqs       <= adc_and;                  // see [R20]
      nmi_wd_reset_request       <= nmi_wd_expired;           // see [R16]
    end
  end

  assign hard_fault_exception = exc_pend[VEC_HARD];

  a_reset_first: assert property ( // see [R1]
    @(posedge core_clk) disable iff (rst)
    pend[VEC_RESET] |-> win_found && win_vec == VEC_RESET)
    else $error("reset request not ranked first");

  a_nmi_second: assert property ( // see [R2]
    @(posedge core_clk) disable iff (rst)
    (pend[VEC_NMI] && !pend[VEC_RESET]) |-> win_vec == VEC_NMI)
    else $error("nmi not ranked second");

  a_fault_escalates: assert property ( // see [R3]
    @(posedge core_clk) disable iff (rst)
    |(fault_raise & ~fault_enable) |=> hard_fault_exception)
    else $error("disabled fault did not escalate");

  a_core_exc_pends: assert property ( // see [R4]
    @(posedge core_clk) disable iff (rst)
    svc_request |=> exc_pend[VEC_SVC])
    else $error("supervisor call not pending");

  a_entry_address: assert property ( // see [R5]
    @(posedge core_clk) disable iff (rst)
    (exc_valid && $past(vector_table_offset) == vector_table_offset)
    |-> exc.handler_addr ==
        vector_table_offset + {23'h0, exc.vector, 2'b00})
    else $error("handler address does not match vector");

  a_reserved_quiet: assert property ( // see [R6]
    @(posedge core_clk) disable iff (rst)
    exc_valid |-> !(exc.vector inside {7'h07, 7'h08, 7'h09, 7'h0a, 7'h0d}))
    else $error("reserved vector presented");

  a_prio_reset: assert property ( // see [R7]
    @(posedge core_clk) disable iff (rst)
    (!after_rst || $past(reset_req_rise)) |-> prio_q == '0)
    else $error("priority not zero after reset");

  a_stack_entry: assert property ( // see [R8]
    @(posedge core_clk) disable iff (rst)
    (exc_valid && exc.vector == VEC_RESET)
    |-> exc.sp_addr == vector_table_offset &&
        exc.handler_addr == exc.sp_addr + ENTRY_BYTES)
    else $error("reset fetch addresses wrong");

  a_nmi_sources: assert property ( // see [R9]
    @(posedge core_clk) disable iff (rst)
    (clock_fail || ctrl_pie_error || ctrl_nmi_wd_timeout)
    |=> nonmaskable_interrupt_line)
    else $error("nmi source not reflected");

  a_adc_and_route: assert property ( // see [R20]
    @(posedge core_clk) disable iff (rst)
    (adc1_eoc[0] && adc2_eoc[0] && irq_enable[IRQ_ADC])
    |-> pend[IRQ_ADC + 16] ##1 conversion_done_irqs[0])
    else $error("conversion interrupt not routed");

  a_wdog_shared: assert property ( // see [R12]
    @(posedge core_clk) disable iff (rst)
    (wdog_irq[1] && irq_enable[IRQ_WDOG]) |-> pend[IRQ_WDOG + 16])
    else $error("watchdog interrupt not on shared line");

  a_dma_direct: assert property ( // see [R14]
    @(posedge core_clk) disable iff (rst)
    (dma_req[0] && !dma_chan_enable[0] && irq_enable[DMA_IRQ_MAP[0]])
    |-> pend[DMA_IRQ_MAP[0] + 16] && !dma_engine_req[0])
    else $error("disabled channel not routed to interrupt");

  a_vtor_range: assert property ( // see [R18]
    @(posedge core_clk) disable iff (rst)
    vector_table_offset == VTOR_RESET ||
    (vector_table_offset >= VTOR_MIN && vector_table_offset <= VTOR_MAX &&
     vector_table_offset[8:0] == 9'h000))
    else $error("table base out of range");

  a_nmi_wd_reset: assert property ( // see [R16]
    @(posedge core_clk) disable iff (rst)
    nmi_wd_expired |=> nmi_wd_reset_request)
    else $error("nmi watchdog reset request missing");

  c_reset_vector: cover property (
    @(posedge core_clk) disable iff (rst)
    exc_valid && exc.vector == VEC_RESET && core_ack);

  c_nmi_taken: cover property (
    @(posedge core_clk) disable iff (rst)
    take && exc.vector == VEC_NMI);

  c_escalation: cover property (
    @(posedge core_clk) disable iff (rst)
    escalate ##[1:4] (take && exc.vector == VEC_HARD));

  c_relocated: cover property (
    @(posedge core_clk) disable iff (rst)
    vtor_ok ##[1:8] (exc_valid && exc.vector >= IRQ_VEC_BASE));
endmodule
`default_nettype wire

// >>> design/mvc_pkg.sv
/*
  Shared constants, carrier types and helper functions for the master
  vector controller. Assumes one 40 MHz core clock and a core that
  fetches handlers from the addresses this controller computes.

  // Function
  // [R1] Resets own the highest fixed priority level.
  // [R2] Non-maskable interrupt is second, above hard fault.
  // [R3] Disabled or unserviceable faults escalate to hard fault.
  // [R4] Core exceptions are prioritized alongside peripheral requests.
  // [R5] Interrupt bit n uses vector n+16, entry 0x40+4n.
  // [R6] Core exceptions use vectors 1-15, some reserved.
  // [R7] Programmable priorities come out of reset as zero.
  // [R8] Stack pointer entry sits at table offset zero.
  // [R9] Four sources raise the non-maskable interrupt.
  // [R10] Access and uncorrectable memory errors raise bus fault.
  // [R11] Single-bit errors and PLL unlock are maskable interrupts.
  // [R12] Both watchdogs share interrupt bit 18, vector 34.
  // [R13] Enabled DMA channels forward the peripheral handshake.
  // [R14] Disabled DMA channel routes handshake to interrupt.
  // [R15] Watchdog, CAN, I2C, conversion interrupts bypass DMA.
  // [R16] NMI watchdog only requests a reset.
  // [R17] Table base is zero after system reset.
  // [R18] Privileged writes relocate base within allowed range.
  // [R19] Software writes only 512-byte aligned offsets.
  // [R20] Each conversion interrupt ANDs both converters' sources.
  // [R21] Equal priority ties go to lowest vector.
*/
package mvc_pkg;

  localparam int NUM_VEC    = 108;
  localparam int NUM_IRQ    = 92;
  localparam int NUM_DMA_CH = 16;
  localparam int NUM_FAULT  = 3;

  typedef logic [6:0] mvc_vec_t;
  typedef logic [4:0] mvc_key_t;
  typedef logic [2:0] mvc_prio_t;

  localparam mvc_vec_t VEC_NONE     = 7'h00;
  localparam mvc_vec_t VEC_RESET    = 7'h01;
  localparam mvc_vec_t VEC_NMI      = 7'h02;
  localparam mvc_vec_t VEC_HARD     = 7'h03;
  localparam mvc_vec_t VEC_MEM      = 7'h04;
  localparam mvc_vec_t VEC_BUS      = 7'h05;
  localparam mvc_vec_t VEC_USAGE    = 7'h06;
  localparam mvc_vec_t VEC_SVC      = 7'h0b;
  localparam mvc_vec_t VEC_DEBUG    = 7'h0c;
  localparam mvc_vec_t VEC_PENDSV   = 7'h0e;
  localparam mvc_vec_t VEC_SYSTICK  = 7'h0f;
  localparam mvc_vec_t IRQ_VEC_BASE = 7'h10;
  localparam mvc_vec_t VEC_LAST     = 7'h6b;

  localparam int IRQ_I2C0      = 8;
  localparam int IRQ_WDOG      = 18;
  localparam int IRQ_I2C1      = 37;
  localparam int IRQ_DMA_SW    = 46;
  localparam int IRQ_CAN       = 64;
  localparam int IRQ_ADC       = 72;
  localparam int IRQ_IPC       = 80;
  localparam int IRQ_RAM_SEC   = 88;
  localparam int IRQ_PLL       = 89;
  localparam int IRQ_FLASH_SEC = 90;

  localparam int DMA_IRQ_MAP [NUM_DMA_CH] =
    '{0, 1, 2, 3, 4, 5, 6, 7, 19, 20, 21, 22, 23, 24, 30, 31};

  localparam logic [31:0] VTOR_RESET      = 32'h0000_0000;
  localparam logic [31:0] VTOR_MIN        = 32'h0000_0200;
  localparam logic [31:0] VTOR_MAX        = 32'h3fff_fe00;
  localparam logic [31:0] SP_ENTRY_OFFSET = 32'h0000_0000;
  localparam logic [31:0] ENTRY_BYTES     = 32'h0000_0004;
  localparam int          VTOR_ALIGN_BITS = 9;

  localparam mvc_key_t  KEY_RESET     = 5'h00;
  localparam mvc_key_t  KEY_NMI       = 5'h01;
  localparam mvc_key_t  KEY_HARD      = 5'h02;
  localparam mvc_key_t  KEY_PROG_BASE = 5'h03;
  localparam mvc_key_t  KEY_IDLE      = 5'h1f;
  localparam mvc_prio_t PRIO_RESET    = 3'h0;

  typedef struct packed {
    mvc_vec_t    vector;
    logic [31:0] handler_addr;
    logic [31:0] sp_addr;
    logic        asynchronous;
  } mvc_exc_t;

  typedef struct packed {
    logic      en;
    mvc_vec_t  vector;
    mvc_prio_t level;
  } mvc_prio_wr_t;

  typedef struct packed {
    logic        en;
    logic        privileged;
    logic [31:0] data;
  } mvc_vtor_wr_t;

  function automatic logic mvc_is_prog(input mvc_vec_t vec);
    return (vec inside {VEC_MEM, VEC_BUS, VEC_USAGE, VEC_SVC, VEC_DEBUG,
                        VEC_PENDSV, VEC_SYSTICK}) ||
           (vec >= IRQ_VEC_BASE && vec <= VEC_LAST);
  endfunction

  function automatic mvc_key_t mvc_key(input mvc_vec_t vec,
                                       input mvc_prio_t prio);
    case (vec)
      VEC_RESET: return KEY_RESET;
      VEC_NMI:   return KEY_NMI;
      VEC_HARD:  return KEY_HARD;
      default:   return KEY_PROG_BASE + {2'h0, prio};
    endcase
  endfunction

  function automatic logic [31:0] mvc_entry_addr(input logic [31:0] base,
                                                 input mvc_vec_t vec);
    return base + {23'h0, vec, 2'b00};
  endfunction

endpackage

// >>> design/mvc_sync.sv
/*
  Two-stage synchroniser for levels arriving from pins.
  Assumes the input is a slow level; pulses that span no rising clock edge are lost.
*/
`timescale 1ns/1ps
`default_nettype none
module mvc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/master_interrupt_vectoring_tb_top.sv
/* Bench for the vector controller with a core model on the far side.
   Assumes the core model acknowledges every presented vector. */
`timescale 1ns/1ps
`default_nettype none
module master_interrupt_vectoring_tb_top;
  import mvc_pkg::*;
  logic core_clk = 0, rst = 1, core_ack, core_return, exc_valid;
  logic power_on_reset_request = 0, system_reset_request = 0;
  logic clock_fail = 0, ctrl_pie_error = 0, ctrl_nmi_wd_timeout = 0;
  logic ext_nmi_pin = 0, nmi_wd_expired = 0, mem_manage_fault = 0;
  logic usage_fault = 0, bus_access_error = 0, bus_access_imprecise = 0;
  logic ram_uncorr_error = 0, flash_uncorr_error = 0, svc_request = 0;
  logic debug_mon_request = 0, pendsv_request = 0, systick_request = 0;
  logic dma_done_irq = 0, ram_single_error = 0, pll_unlock = 0;
  logic flash_single_error = 0, vtor_wr_rejected, hard_fault_exception;
  logic nonmaskable_interrupt_line, nmi_wd_reset_request;
  logic [2:0] fault_enable = '1;
  logic [91:0] periph_irq = '0, irq_enable = '1;
  logic [15:0] dma_req = '0, dma_chan_enable = '0, dma_engine_req;
  logic [1:0] wdog_irq = '0, i2c_irq = '0;
  logic [3:0] can_irq = '0, control_to_master_ipc_irq = '0;
  logic [7:0] adc1_eoc = '0, adc2_eoc = '0, conversion_done_irqs;
  mvc_prio_wr_t prio_wr = '0;
  mvc_vtor_wr_t vtor_wr = '0;
  mvc_exc_t exc;
  mvc_vec_t active_vector;
  logic [31:0] vector_table_offset, base = 0;
  int n_errors = 0, total_checks = 0;

  mvc_controller i_dut (.*);
  mvc_core_model i_core (.*);

  always #12.5 core_clk = ~core_clk;

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits for a presentation, bounded, checks it, then lets the core
  // model take it and checks the vector that became active.
  task automatic take(logic [6:0] v);
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge core_clk);
      #1;
      if (exc_valid === 1'b1) break;
    end
    if (i == 30) begin
      n_errors++;
      conclude();
    end else begin
      chk("vector", v, exc.vector);
      chk("handler", base + 4 * v, exc.handler_addr);
      chk("stack", base, exc.sp_addr);
      chk("async", !(v inside {3, 4, 6, 11, 12}), exc.asynchronous);
      cyc(2);
      #1;
      chk("active", v, active_vector);
      cyc(1);
    end
  endtask

  task automatic vtor(logic [31:0] d, logic ok);
    vtor_wr <= '{1'b1, 1'b1, d};
    cyc(1);
    vtor_wr <= '0;
    #1;
    chk("reject", !ok, vtor_wr_rejected);
    if (ok) base = d;
    chk("base", base, vector_table_offset);
    cyc(1);
  endtask

  task automatic sc_svc();
    svc_request <= 1;
    cyc(1);
    svc_request <= 0;
    take(11);
  endtask

  task automatic sc_wdog();
    wdog_irq[1] <= 1;
    take(34);
    wdog_irq <= 0;
  endtask

  task automatic sc_dma();
    dma_chan_enable[0] <= 1;
    dma_req[0] <= 1;
    @(posedge core_clk);
    #1;
    chk("dma", 1, dma_engine_req[0]);
    @(posedge core_clk);
    dma_chan_enable <= 0;
    take(16);
    dma_req <= 0;
  endtask

  task automatic sc_adc();
    adc1_eoc <= 8'h81;
    adc2_eoc <= 8'h01;
    take(88);
    chk("adc", 1, conversion_done_irqs);
    adc1_eoc <= 0;
    adc2_eoc <= 0;
  endtask

  task automatic sc_fault();
    fault_enable <= 3'h3;
    usage_fault <= 1;
    cyc(1);
    usage_fault <= 0;
    #1;
    chk("hard", 1, hard_fault_exception);
    take(3);
  endtask

  task automatic sc_nmi_wd();
    nmi_wd_expired <= 1;
    cyc(1);
    #1;
    chk("wd", 1, nmi_wd_reset_request);
    chk("nmi", 0, nonmaskable_interrupt_line);
    @(posedge core_clk);
    nmi_wd_expired <= 0;
  endtask

  // The NMI pends on the same edge the tied lines rise and outranks them, so it is the
  // first vector shown; the tie then goes to the lower vector.
  task automatic sc_nmi_tie();
    clock_fail <= 1;
    cyc(1);
    periph_irq[29:28] <= 2'h3;
    take(2);
    take(44);
    periph_irq <= '0;
    clock_fail <= 0;
  endtask

  task automatic sc_pin_nmi();
    ext_nmi_pin <= 1;
    take(2);
    chk("nmi", 1, nonmaskable_interrupt_line);
    ext_nmi_pin <= 0;
  endtask

  // A lowered level on vector 44 lets 45 win; a reset request then
  // restores the base and every priority, so 44 wins again.
  task automatic sc_prio_reset();
    prio_wr <= '{1'b1, 7'd44, 3'h1};
    cyc(1);
    prio_wr <= '0;
    periph_irq[29:28] <= 2'h3;
    take(45);
    periph_irq <= '0;
    cyc(8);
    system_reset_request <= 1;
    base = 0;
    take(1);
    chk("base", 0, vector_table_offset);
    system_reset_request <= 0;
    periph_irq[29:28] <= 2'h3;
    take(44);
    periph_irq <= '0;
  endtask

  initial begin
    cyc(2);
    rst <= 0;
    cyc(2);
    chk("base", 0, vector_table_offset);
    sc_svc();
    cyc(8);
    vtor(32'h400, 1);
    vtor(32'h410, 0);
    sc_wdog();
    cyc(8);
    sc_dma();
    cyc(8);
    sc_adc();
    cyc(8);
    sc_fault();
    cyc(8);
    sc_nmi_wd();
    sc_nmi_tie();
    cyc(8);
    sc_pin_nmi();
    cyc(8);
    sc_prio_reset();
    cyc(12);
    conclude();
  end
endmodule
`default_nettype wire

// >>> testbench/mvc_core_model.sv
/* Core model: takes each presented vector and ends its handler later.
   Assumes exc_valid stays up until the core acknowledges it. */
`timescale 1ns/1ps
`default_nettype none
module mvc_core_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic exc_valid,
  output var  logic core_ack,
  output var  logic core_return
);
  logic [3:0] run;
  assign core_return = run[3];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_ack <= 1'b0;
      run      <= 4'h0;
    end else begin
      core_ack <= exc_valid & ~core_ack;
      run      <= {run[2:0], core_ack};
    end
  end
endmodule
`default_nettype wire
